// ==== hw/goc_level_timer.sv ====
// pickup delay timer counting quarter-cycle ticks
module goc_level_timer #(
	parameter int CNT_W = 17
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tick_in,
	input wire logic start_in,
	input wire logic [CNT_W-1:0] threshold_in,
	output logic fired_out
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic fired_q;
	logic fired_d;

	if (CNT_W < 2) begin : g_chk
		$error("goc_level_timer: CNT_W too small");
	end

	// counter saturates at threshold so a long pickup cannot wrap
	always_comb begin
		cnt_d = cnt_q;
		fired_d = 1'b0;
		if (!start_in) begin
			cnt_d = '0; // see R18
		end else if (cnt_q >= threshold_in) begin
			fired_d = 1'b1; // see R17
		end else if (tick_in) begin
			cnt_d = cnt_q + CNT_W'(1); // see R18
		end
	end

	// registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= '0;
			fired_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			fired_q <= fired_d;
		end
	end

	assign fired_out = fired_q;
endmodule

// ==== hw/goc_overcurrent_levels.sv ====
// multi-level instantaneous and definite-time overcurrent elements
//
// What this block does
// R1: phase-to-phase pickup per pair and level
// R2: neutral four timed levels, 5-6 instantaneous
// R3: extra level-2 blocking element per family
// R4: timed delays 0..16000 cycles, quarter steps
// R5: blocking delay 0..60 cycles, independent
// R6: sensitive neutral channel adds two cycles
// R7: programmed delay runs in series
// R8: residual operates on sum of phases
// R9: residual four timed levels, 5-6 instantaneous
// R10: low residual pickup adds two cycles
// R11: negative sequence with rotation swap option
// R12: negseq four timed levels, 5-6 instantaneous
// R13: all families share the phase structure
// R14: strict greater compare, level is any-phase
// R15: direction disabled forces qualifier high
// R16: torque low disables its level
// R17: timed output after continuous pickup, instant clear
// R18: timers count quarter ticks, restart on drop
module goc_overcurrent_levels #(
	parameter int QTR_CLKS = goc_pkg::QTR_CLKS
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic signed [goc_pkg::PHASOR_W-1:0] phase_a_re_in,
	input wire logic signed [goc_pkg::PHASOR_W-1:0] phase_a_im_in,
	input wire logic signed [goc_pkg::PHASOR_W-1:0] phase_b_re_in,
	input wire logic signed [goc_pkg::PHASOR_W-1:0] phase_b_im_in,
	input wire logic signed [goc_pkg::PHASOR_W-1:0] phase_c_re_in,
	input wire logic signed [goc_pkg::PHASOR_W-1:0] phase_c_im_in,
	input wire logic [goc_pkg::MAG_W-1:0] neutral_mag_in,
	input wire logic reverse_rotation_in,
	input wire logic neutral_sensitive_in,
	input wire logic residual_one_amp_in,
	input wire logic direction_control_enable_in,
	input wire logic [2:0] ph_ph_level_count_in,
	input wire logic [goc_pkg::PP_LEVELS-1:0][goc_pkg::MAG_W-1:0] ph_ph_pickup_in,
	input wire logic [2:0] neutral_level_count_in,
	input wire logic [2:0] residual_level_count_in,
	input wire logic [2:0] negseq_level_count_in,
	input wire logic [goc_pkg::LEVELS-1:0][goc_pkg::MAG_W-1:0] neutral_pickup_in,
	input wire logic [goc_pkg::LEVELS-1:0][goc_pkg::MAG_W-1:0] residual_pickup_in,
	input wire logic [goc_pkg::LEVELS-1:0][goc_pkg::MAG_W-1:0] negseq_pickup_in,
	input wire logic [goc_pkg::TIMED_LEVELS-1:0][goc_pkg::SET_DLY_W-1:0] neutral_delay_in,
	input wire logic [goc_pkg::TIMED_LEVELS-1:0][goc_pkg::SET_DLY_W-1:0] residual_delay_in,
	input wire logic [goc_pkg::TIMED_LEVELS-1:0][goc_pkg::SET_DLY_W-1:0] negseq_delay_in,
	input wire logic [goc_pkg::BLK_DLY_W-1:0] neutral_blocking_delay_in,
	input wire logic [goc_pkg::BLK_DLY_W-1:0] residual_blocking_delay_in,
	input wire logic [goc_pkg::BLK_DLY_W-1:0] negseq_blocking_delay_in,
	input wire logic [goc_pkg::TIMED_LEVELS-1:0] neutral_direction_in,
	input wire logic [goc_pkg::TIMED_LEVELS-1:0] residual_direction_in,
	input wire logic [goc_pkg::TIMED_LEVELS-1:0] negseq_direction_in,
	input wire logic [goc_pkg::TIMED_LEVELS-1:0] neutral_torque_in,
	input wire logic [goc_pkg::TIMED_LEVELS-1:0] residual_torque_in,
	input wire logic [goc_pkg::TIMED_LEVELS-1:0] negseq_torque_in,
	output logic [goc_pkg::PP_LEVELS-1:0] ph_ph_ab_out,
	output logic [goc_pkg::PP_LEVELS-1:0] ph_ph_bc_out,
	output logic [goc_pkg::PP_LEVELS-1:0] ph_ph_ca_out,
	output logic [goc_pkg::PP_LEVELS-1:0] ph_ph_level_out,
	output logic [goc_pkg::LEVELS-1:0] neutral_inst_out,
	output logic [goc_pkg::LEVELS-1:0] residual_inst_out,
	output logic [goc_pkg::LEVELS-1:0] negseq_inst_out,
	output logic [goc_pkg::TIMED_LEVELS-1:0] neutral_timed_out,
	output logic [goc_pkg::TIMED_LEVELS-1:0] residual_timed_out,
	output logic [goc_pkg::TIMED_LEVELS-1:0] negseq_timed_out,
	output logic neutral_blocking_element_out,
	output logic residual_blocking_element_out,
	output logic negseq_blocking_element_out
);
	localparam int S_W = goc_pkg::PHASOR_W + 4;
	localparam int SQ_W = 2 * S_W + 1;
	localparam int NF = goc_pkg::NUM_FAM;
	localparam int NL = goc_pkg::LEVELS;
	localparam int NT = goc_pkg::TIMED_LEVELS;
	localparam int CW = goc_pkg::CNT_W;

	if (QTR_CLKS < 1 || QTR_CLKS >= (1 << 20)) begin : g_chk
		$error("goc_overcurrent_levels: QTR_CLKS out of range");
	end

	// squared magnitude of a phasor, avoids a square root
	function automatic logic [SQ_W-1:0] mag_sq(input logic signed [S_W-1:0] re,
		input logic signed [S_W-1:0] im);
		logic [2*S_W-1:0] r2;
		logic [2*S_W-1:0] i2;
		// widen before multiplying so the square keeps its top bits
		r2 = (2*S_W)'(re) * (2*S_W)'(re);
		i2 = (2*S_W)'(im) * (2*S_W)'(im);
		return SQ_W'({1'b0, r2} + {1'b0, i2});
	endfunction

	function automatic logic [SQ_W-1:0] pick_sq(input logic [goc_pkg::MAG_W-1:0] p);
		return SQ_W'(p) * SQ_W'(p);
	endfunction

	// reset release through two flops
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// quarter-cycle tick divider
	logic [19:0] div_q;
	logic [19:0] div_d;
	logic tick_q;
	logic tick_d;
	always_comb begin
		div_d = div_q + 20'h00001;
		tick_d = 1'b0;
		if (div_q >= 20'(QTR_CLKS - 1)) begin
			div_d = 20'h00000;
			tick_d = 1'b1; // see R18
		end
	end
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			div_q <= 20'h00000;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	// operating quantities, all squared
	logic signed [S_W-1:0] ar, ai, br, bi, cr, ci, kr, ki, qr, qi;
	logic signed [S_W+15:0] kpr, kpi;
	logic [SQ_W-1:0] op_sq [NF];
	logic [SQ_W-1:0] pp_sq [3];
	always_comb begin
		ar = S_W'(phase_a_re_in);
		ai = S_W'(phase_a_im_in);
		br = S_W'(phase_b_re_in);
		bi = S_W'(phase_b_im_in);
		cr = S_W'(phase_c_re_in);
		ci = S_W'(phase_c_im_in);
		pp_sq[0] = mag_sq(ar - br, ai - bi); // see R1
		pp_sq[1] = mag_sq(br - cr, bi - ci);
		pp_sq[2] = mag_sq(cr - ar, ci - ai);
		op_sq[goc_pkg::FAM_NEUTRAL] = SQ_W'(neutral_mag_in) * SQ_W'(neutral_mag_in);
		op_sq[goc_pkg::FAM_RESIDUAL] = mag_sq(ar + br + cr, ai + bi + ci); // see R8
		// a^2*b + a*c: shared half term, sqrt3/2 term flips with rotation
		kpr = (S_W+16)'(bi - ci) * (S_W+16)'(goc_pkg::SQRT3_HALF_Q14);
		kpi = (S_W+16)'(cr - br) * (S_W+16)'(goc_pkg::SQRT3_HALF_Q14);
		kr = S_W'(kpr >>> goc_pkg::ROT_FRAC);
		ki = S_W'(kpi >>> goc_pkg::ROT_FRAC);
		qr = ar - ((br + cr) >>> 1) + (reverse_rotation_in ? -kr : kr); // see R11
		qi = ai - ((bi + ci) >>> 1) + (reverse_rotation_in ? -ki : ki);
		op_sq[goc_pkg::FAM_NEGSEQ] = mag_sq(qr, qi);
	end

	// per-family settings gathered into arrays
	logic [goc_pkg::MAG_W-1:0] pick_set [NF][NL];
	logic [2:0] lvl_cnt [NF];
	logic [NT-1:0] dir_set [NF];
	logic [NT-1:0] trq_set [NF];
	logic [goc_pkg::SET_DLY_W-1:0] dly_set [NF][NT];
	logic [goc_pkg::BLK_DLY_W-1:0] blk_set [NF];
	always_comb begin
		lvl_cnt[0] = neutral_level_count_in;
		lvl_cnt[1] = residual_level_count_in;
		lvl_cnt[2] = negseq_level_count_in;
		dir_set[0] = neutral_direction_in;
		dir_set[1] = residual_direction_in;
		dir_set[2] = negseq_direction_in;
		trq_set[0] = neutral_torque_in;
		trq_set[1] = residual_torque_in;
		trq_set[2] = negseq_torque_in;
		blk_set[0] = neutral_blocking_delay_in;
		blk_set[1] = residual_blocking_delay_in;
		blk_set[2] = negseq_blocking_delay_in;
		for (int k = 0; k < NL; k++) begin
			pick_set[0][k] = neutral_pickup_in[k];
			pick_set[1][k] = residual_pickup_in[k];
			pick_set[2][k] = negseq_pickup_in[k];
		end
		for (int k = 0; k < NT; k++) begin
			dly_set[0][k] = neutral_delay_in[k];
			dly_set[1][k] = residual_delay_in[k];
			dly_set[2][k] = negseq_delay_in[k];
		end
	end

	// registered comparators; a level beyond the count never picks up
	logic [NL-1:0] pick_q [NF];
	logic [NL-1:0] pick_d [NF];
	logic [goc_pkg::PP_LEVELS-1:0] pab_q, pbc_q, pca_q, pab_d, pbc_d, pca_d;
	always_comb begin
		for (int f = 0; f < NF; f++) begin
			for (int k = 0; k < NL; k++) begin
				pick_d[f][k] = (k < int'(lvl_cnt[f])) && (op_sq[f] > pick_sq(pick_set[f][k])); // see R2 R9 R12 R14
			end
		end
		for (int k = 0; k < goc_pkg::PP_LEVELS; k++) begin
			pab_d[k] = (k < int'(ph_ph_level_count_in)) && (pp_sq[0] > pick_sq(ph_ph_pickup_in[k])); // see R1 R14
			pbc_d[k] = (k < int'(ph_ph_level_count_in)) && (pp_sq[1] > pick_sq(ph_ph_pickup_in[k]));
			pca_d[k] = (k < int'(ph_ph_level_count_in)) && (pp_sq[2] > pick_sq(ph_ph_pickup_in[k]));
		end
	end
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			for (int f = 0; f < NF; f++) begin
				pick_q[f] <= '0;
			end
			pab_q <= '0;
			pbc_q <= '0;
			pca_q <= '0;
		end else begin
			pick_q <= pick_d;
			pab_q <= pab_d;
			pbc_q <= pbc_d;
			pca_q <= pca_d;
		end
	end

	// qualification and timer thresholds
	logic [NL-1:0] qual [NF];
	logic [CW-1:0] extra [NF];
	logic [CW-1:0] thr_t [NF][NT];
	logic [CW-1:0] thr_b [NF];
	logic low_res;
	always_comb begin
		low_res = 1'b0;
		for (int k = 0; k < NL; k++) begin
			if (k < int'(residual_level_count_in) && residual_pickup_in[k] <
				(residual_one_amp_in ? goc_pkg::LOW_PICKUP_1A : goc_pkg::LOW_PICKUP_5A)) begin
				low_res = 1'b1; // see R10
			end
		end
		extra[goc_pkg::FAM_NEUTRAL] = neutral_sensitive_in ? goc_pkg::FIXED_DELAY_TICKS : '0; // see R6
		extra[goc_pkg::FAM_RESIDUAL] = low_res ? goc_pkg::FIXED_DELAY_TICKS : '0; // see R10
		extra[goc_pkg::FAM_NEGSEQ] = '0;
		for (int f = 0; f < NF; f++) begin
			qual[f] = pick_q[f];
			for (int k = 0; k < NT; k++) begin
				// see R13 R15 R16
				qual[f][k] = pick_q[f][k] && (dir_set[f][k] || !direction_control_enable_in) && trq_set[f][k];
				thr_t[f][k] = CW'((dly_set[f][k] > goc_pkg::MAX_DELAY_TICKS) ?
					goc_pkg::MAX_DELAY_TICKS : dly_set[f][k]) + extra[f]; // see R4 R7
			end
			thr_b[f] = CW'((blk_set[f] > goc_pkg::MAX_BLOCK_TICKS) ?
				goc_pkg::MAX_BLOCK_TICKS : blk_set[f]) + extra[f]; // see R5 R7
		end
	end

	// one timer per neutral, residual and negseq output; instantaneous outputs only carry the fixed delay
	logic [NL-1:0] inst_v [NF];
	logic [NT-1:0] timed_v [NF];
	logic [NF-1:0] blk_v;
	for (genvar f = 0; f < NF; f++) begin : g_fam
		for (genvar k = 0; k < NL; k++) begin : g_inst
			goc_level_timer #(.CNT_W(CW)) u_inst (
				.clk_in(clk_in),
				.rst_n_in(rst_sync_q),
				.tick_in(tick_q),
				.start_in(qual[f][k]),
				.threshold_in(extra[f]),
				.fired_out(inst_v[f][k])
			);
		end
		for (genvar k = 0; k < NT; k++) begin : g_timed
			goc_level_timer #(.CNT_W(CW)) u_timed (
				.clk_in(clk_in),
				.rst_n_in(rst_sync_q),
				.tick_in(tick_q),
				.start_in(qual[f][k]),
				.threshold_in(thr_t[f][k]),
				.fired_out(timed_v[f][k])
			);
		end
		// blocking copy of level 2 with its own delay, see R3
		goc_level_timer #(.CNT_W(CW)) u_blk (
			.clk_in(clk_in),
			.rst_n_in(rst_sync_q),
			.tick_in(tick_q),
			.start_in(qual[f][goc_pkg::BLOCKING_LEVEL_IDX]),
			.threshold_in(thr_b[f]),
			.fired_out(blk_v[f])
		);
	end

	// outputs
	assign ph_ph_ab_out = pab_q;
	assign ph_ph_bc_out = pbc_q;
	assign ph_ph_ca_out = pca_q;
	assign ph_ph_level_out = pab_q | pbc_q | pca_q; // see R14
	assign neutral_inst_out = inst_v[goc_pkg::FAM_NEUTRAL];
	assign residual_inst_out = inst_v[goc_pkg::FAM_RESIDUAL];
	assign negseq_inst_out = inst_v[goc_pkg::FAM_NEGSEQ];
	assign neutral_timed_out = timed_v[goc_pkg::FAM_NEUTRAL];
	assign residual_timed_out = timed_v[goc_pkg::FAM_RESIDUAL];
	assign negseq_timed_out = timed_v[goc_pkg::FAM_NEGSEQ];
	assign neutral_blocking_element_out = blk_v[goc_pkg::FAM_NEUTRAL];
	assign residual_blocking_element_out = blk_v[goc_pkg::FAM_RESIDUAL];
	assign negseq_blocking_element_out = blk_v[goc_pkg::FAM_NEGSEQ];
endmodule

// ==== hw/goc_pkg.sv ====
// constants shared by the overcurrent level logic
package goc_pkg;
	localparam int MAG_W = 16;
	localparam int PHASOR_W = 16;
	localparam int SET_DLY_W = 16;
	localparam int BLK_DLY_W = 8;
	localparam int CNT_W = 17;
	localparam int LEVELS = 6;
	localparam int TIMED_LEVELS = 4;
	localparam int PP_LEVELS = 4;
	localparam int NUM_FAM = 3;
	localparam int FAM_NEUTRAL = 0;
	localparam int FAM_RESIDUAL = 1;
	localparam int FAM_NEGSEQ = 2;
	localparam int BLOCKING_LEVEL_IDX = 1;
	localparam int CLK_HZ = 10_000_000;
	localparam int LINE_HZ = 60;
	localparam int TICKS_PER_CYCLE = 4;
	localparam int QTR_CLKS = CLK_HZ / (LINE_HZ * TICKS_PER_CYCLE);
	localparam int MAX_DELAY_CYCLES = 16000;
	localparam int MAX_BLOCK_CYCLES = 60;
	localparam logic [SET_DLY_W-1:0] MAX_DELAY_TICKS = SET_DLY_W'(MAX_DELAY_CYCLES * TICKS_PER_CYCLE);
	localparam logic [BLK_DLY_W-1:0] MAX_BLOCK_TICKS = BLK_DLY_W'(MAX_BLOCK_CYCLES * TICKS_PER_CYCLE);
	localparam int FIXED_DELAY_CYCLES = 2;
	localparam logic [CNT_W-1:0] FIXED_DELAY_TICKS = CNT_W'(FIXED_DELAY_CYCLES * TICKS_PER_CYCLE);
	localparam int PICKUP_LSB_MA = 10;
	localparam int LOW_PICKUP_5A_MA = 250;
	localparam int LOW_PICKUP_1A_MA = 50;
	localparam logic [MAG_W-1:0] LOW_PICKUP_5A = MAG_W'(LOW_PICKUP_5A_MA / PICKUP_LSB_MA);
	localparam logic [MAG_W-1:0] LOW_PICKUP_1A = MAG_W'(LOW_PICKUP_1A_MA / PICKUP_LSB_MA);
	localparam int ROT_FRAC = 14;
	localparam logic signed [15:0] SQRT3_HALF_Q14 = 16'sh376d;
endpackage

// ==== test/goc_front_end.sv ====
// measurement front end model feeding phase phasors to the level block
module goc_front_end (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [5:0][15:0] want_in,
	output logic [5:0][15:0] phasor_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// one sample of latency, as a real measurement stage adds
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phasor_out <= '0;
		end else begin
			phasor_out <= want_in;
		end
	end
endmodule

// ==== test/goc_overcurrent_levels_props.sv ====
// port checks for the overcurrent level block
module goc_level_props #(
	parameter int QTR_CLKS = 4
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [15:0] neutral_mag_in,
	input wire logic neutral_sensitive_in,
	input wire logic direction_control_enable_in,
	input wire logic [2:0] neutral_level_count_in,
	input wire logic [2:0] residual_level_count_in,
	input wire logic [5:0][15:0] neutral_pickup_in,
	input wire logic [3:0][15:0] neutral_delay_in,
	input wire logic [7:0] neutral_blocking_delay_in,
	input wire logic [3:0] neutral_direction_in,
	input wire logic [3:0] neutral_torque_in,
	input wire logic [5:0] neutral_inst_out,
	input wire logic [5:0] residual_inst_out,
	input wire logic [3:0] neutral_timed_out,
	input wire logic neutral_blocking_element_out
);
	logic qual;
	int cnt_q;
	int cnt_d;
	int fix;
	// qualified pickup age of level 1; lower bounds only hold while it restarts on any loss
	always_comb begin
		qual = neutral_mag_in > neutral_pickup_in[0] && neutral_torque_in[0] && neutral_level_count_in != 3'h0
			&& (!direction_control_enable_in || neutral_direction_in[0]);
		cnt_d = qual ? cnt_q + 1 : 0;
		fix = neutral_sensitive_in ? 8 : 0;
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_below;
		(neutral_mag_in <= neutral_pickup_in[0])[*2];
	endsequence
	sequence s_cnt0;
		(residual_level_count_in == 3'h0)[*3];
	endsequence
	AST_CNT0: assert property (s_cnt0 |-> residual_inst_out == 6'h00)
		else $error("residual level asserted with zero level count");
	AST_TORQUE: assert property ((neutral_torque_in[0] == 1'b0)[*3] |-> !neutral_timed_out[0])
		else $error("timed level asserted with torque low");
	AST_DIR: assert property ((direction_control_enable_in && !neutral_direction_in[0])[*3] |-> !neutral_timed_out[0])
		else $error("timed level asserted without direction permission");
	AST_DROP: assert property (s_below |=> !neutral_inst_out[0] && !neutral_timed_out[0])
		else $error("neutral level held after pickup dropped");
	AST_SENS_INST: assert property (neutral_sensitive_in && $rose(neutral_inst_out[0]) |-> cnt_q + QTR_CLKS >= 8 * QTR_CLKS)
		else $error("sensitive neutral instantaneous too early");
	AST_TIMED_MIN: assert property ($rose(neutral_timed_out[0])
		|-> cnt_q + QTR_CLKS >= (32'(neutral_delay_in[0]) + fix) * QTR_CLKS)
		else $error("neutral timed level too early");
	AST_BLK_MIN: assert property ($rose(neutral_blocking_element_out)
		|-> cnt_q + QTR_CLKS >= (32'(neutral_blocking_delay_in) + fix) * QTR_CLKS)
		else $error("blocking element too early");
	AST_TIMED_DUE: assert property (cnt_q == (32'(neutral_delay_in[0]) + fix + 1) * QTR_CLKS + 3
		|-> neutral_timed_out[0])
		else $error("neutral timed level late");
	AST_TIMED_INST: assert property (neutral_timed_out[0] |-> neutral_inst_out[0])
		else $error("timed level without its pickup");
endmodule
bind goc_overcurrent_levels goc_level_props #(.QTR_CLKS(QTR_CLKS)) props_u (.*);

// ==== test/test_goc_overcurrent_levels.sv ====
// self-checking bench for the overcurrent level block
module test_goc_overcurrent_levels;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int Q = 4;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic signed [15:0] phase_a_re_in, phase_a_im_in, phase_b_re_in, phase_b_im_in, phase_c_re_in, phase_c_im_in;
	logic [5:0][15:0] want, ph;
	logic [15:0] neutral_mag_in;
	logic reverse_rotation_in, neutral_sensitive_in, residual_one_amp_in, direction_control_enable_in;
	logic [2:0] ph_ph_level_count_in, neutral_level_count_in, residual_level_count_in, negseq_level_count_in;
	logic [3:0][15:0] ph_ph_pickup_in, neutral_delay_in, residual_delay_in, negseq_delay_in;
	logic [5:0][15:0] neutral_pickup_in, residual_pickup_in, negseq_pickup_in;
	logic [7:0] neutral_blocking_delay_in, residual_blocking_delay_in, negseq_blocking_delay_in;
	logic [3:0] neutral_direction_in, residual_direction_in, negseq_direction_in;
	logic [3:0] neutral_torque_in, residual_torque_in, negseq_torque_in;
	logic [3:0] ph_ph_ab_out, ph_ph_bc_out, ph_ph_ca_out, ph_ph_level_out;
	logic [5:0] neutral_inst_out, residual_inst_out, negseq_inst_out;
	logic [3:0] neutral_timed_out, residual_timed_out, negseq_timed_out;
	logic neutral_blocking_element_out, residual_blocking_element_out, negseq_blocking_element_out;
	int bad_count = 0;
	int check_count = 0;
	assign {phase_a_re_in, phase_a_im_in, phase_b_re_in, phase_b_im_in, phase_c_re_in, phase_c_im_in} = ph;
	always #50 clk_in = ~clk_in;
	goc_front_end fe_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .want_in(want), .phasor_out(ph));
	goc_overcurrent_levels #(.QTR_CLKS(Q)) dut_u (.*);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic phase(input logic [15:0] ar, br, bi, cr, ci);
		want = {ar, 16'h0, br, bi, cr, ci};
	endtask
	// same step on the neutral channel and on phase a
	task automatic drive(input logic [15:0] m);
		neutral_mag_in = m;
		phase(m, 16'h0, 16'h0, 16'h0, 16'h0);
	endtask
	task automatic settle();
		repeat (4) @(negedge clk_in);
	endtask
	function automatic logic obs(input int s);
		case (s)
			0: obs = neutral_timed_out[0];
			1: obs = neutral_blocking_element_out;
			2: obs = neutral_inst_out[0];
			default: obs = residual_inst_out[0];
		endcase
	endfunction
	// pickup step, then cycles to the selected output against t quarter ticks
	task automatic meas(input int s, input int t);
		int n;
		n = 0;
		drive(16'h00c8);
		while (obs(s) !== 1'b1 && n < 2000) begin
			@(negedge clk_in);
			n++;
		end
		chk(16'(n >= (t - 1) * Q && n <= (t + 1) * Q + 4), 16'h1);
		drive(16'h0);
		settle();
	endtask
	task automatic t_pick();
		phase(16'h0064, 16'h0, 16'h0, 16'h0, 16'h0);
		settle();
		chk(16'(residual_inst_out[0]), 16'h1);
		residual_pickup_in[0] = 16'h0064;
		settle();
		chk(16'(residual_inst_out[0]), 16'h0);
		residual_pickup_in[0] = 16'h0063;
		phase(16'h0064, 16'hff9c, 16'h0, 16'h0, 16'h0);
		settle();
		chk({ph_ph_ab_out, ph_ph_bc_out, ph_ph_ca_out, ph_ph_level_out}, 16'h3223);
	endtask
	// balanced abc set: no negative sequence until rotation is reversed
	task automatic t_seq();
		phase(16'h0064, 16'hffce, 16'hffa9, 16'hffce, 16'h0057);
		settle();
		chk(16'({negseq_inst_out[0], residual_inst_out[0]}), 16'h0);
		reverse_rotation_in = 1'b1;
		settle();
		chk(16'(negseq_inst_out[0]), 16'h1);
		reverse_rotation_in = 1'b0;
	endtask
	task automatic t_count();
		drive(16'h00c8);
		for (int c = 0; c < 7; c++) begin
			neutral_level_count_in = 3'(c);
			residual_level_count_in = 3'(c);
			negseq_level_count_in = 3'(c);
			settle();
			chk(16'({neutral_inst_out, residual_inst_out}), 16'({2{6'((1 << c) - 1)}}));
			chk(16'(negseq_inst_out), 16'((1 << c) - 1));
			chk(16'({neutral_timed_out, residual_timed_out, negseq_timed_out}), 16'({3{4'((1 << c) - 1)}}));
			chk(16'({neutral_blocking_element_out, residual_blocking_element_out, negseq_blocking_element_out}),
				(c >= 2) ? 16'h0007 : 16'h0000);
		end
		drive(16'h0);
		settle();
	endtask
	task automatic t_timed();
		neutral_delay_in[0] = 16'h0008;
		neutral_delay_in[1] = 16'h0028;
		neutral_blocking_delay_in = 8'h04;
		meas(0, 8);
		meas(1, 4);
		neutral_sensitive_in = 1'b1;
		meas(2, 8);
		meas(0, 16);
		neutral_sensitive_in = 1'b0;
		residual_pickup_in[0] = 16'h0014;
		meas(3, 8);
		residual_one_amp_in = 1'b1;
		meas(3, 0);
		residual_one_amp_in = 1'b0;
		residual_pickup_in[0] = 16'h0063;
	endtask
	task automatic t_qual();
		neutral_delay_in[0] = 16'h0;
		drive(16'h00c8);
		neutral_torque_in = 4'h0;
		settle();
		chk(16'(neutral_timed_out[0]), 16'h0);
		neutral_torque_in = 4'hf;
		direction_control_enable_in = 1'b1;
		neutral_direction_in = 4'h0;
		settle();
		chk(16'(neutral_timed_out[0]), 16'h0);
		direction_control_enable_in = 1'b0;
		settle();
		chk(16'(neutral_timed_out[0]), 16'h1);
		neutral_direction_in = 4'hf;
		drive(16'h0);
	endtask
	task automatic end_sim();
		$display("checks=%0d errors=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// the sequence needs a few hundred cycles; this cuts a hang short
	initial begin
		#2_000_000;
		bad_count++;
		end_sim();
	end
	initial begin
		{reverse_rotation_in, neutral_sensitive_in, residual_one_amp_in, direction_control_enable_in} = 4'h0;
		ph_ph_level_count_in = 3'h4;
		{neutral_level_count_in, residual_level_count_in, negseq_level_count_in} = {3{3'h6}};
		ph_ph_pickup_in = {16'h012c, 16'h00c8, 16'h0063, 16'h0096};
		neutral_pickup_in = {6{16'h0064}};
		residual_pickup_in = {6{16'h0063}};
		negseq_pickup_in = {6{16'h0032}};
		{neutral_delay_in, residual_delay_in, negseq_delay_in} = '0;
		{neutral_blocking_delay_in, residual_blocking_delay_in, negseq_blocking_delay_in} = '0;
		{neutral_direction_in, residual_direction_in, negseq_direction_in} = 12'hfff;
		{neutral_torque_in, residual_torque_in, negseq_torque_in} = 12'hfff;
		want = '0;
		neutral_mag_in = 16'h0;
		repeat (16) @(negedge clk_in);
		rst_n_in = 1'b1;
		settle();
		t_pick();
		t_seq();
		t_count();
		t_timed();
		t_qual();
		settle();
		end_sim();
	end
endmodule
